// *** core/dcp_pkg.sv ***
/*
 * dcp_pkg: constants and types for the channel-change policy block.
 * assumes a single 50 MHz clock; all timeout terms are held in milliseconds.
 */
package dcp_pkg;

   // ==========================================================
   // clock and time base
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   // ==========================================================
   // timeout terms, milliseconds
   localparam logic [15:0] JUMP_DEF_MS  = 16'd1300;
   localparam logic [15:0] TECH1_RNG_MS = 16'd30000;
   // margin for map, ranging burst and processing, 20 to 40 ms
   localparam logic [15:0] RNG_MARGIN_MS = 16'd30;
   localparam logic [17:0] T15_MIN_MS    = 18'd4000;
   localparam logic [17:0] T15_MAX_MS    = 18'd35000;

   // ==========================================================
   // technique codes
   localparam logic [2:0] TECH_REINIT  = 3'h0;
   localparam logic [2:0] TECH_BCAST   = 3'h1;
   localparam logic [2:0] TECH_UNICAST = 3'h2;
   localparam logic [2:0] TECH_EITHER  = 3'h3;
   localparam logic [2:0] TECH_DIRECT  = 3'h4;

   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_JUMP   = 8'h04;
   localparam logic [7:0] OFS_SM_IV  = 8'h08;
   localparam logic [7:0] OFS_RNG_IV = 8'h0c;
   localparam logic [7:0] OFS_COND   = 8'h10;
   localparam logic [7:0] OFS_STAT   = 8'h14;
   localparam logic [7:0] OFS_T15    = 8'h18;
   localparam logic [7:0] OFS_REMAIN = 8'h1c;

   // ctrl fields
   localparam int unsigned CTRL_TECH_LSB = 0;
   localparam int unsigned CTRL_JV_BIT   = 3;
   localparam int unsigned CTRL_ISS_BIT  = 8;
   localparam int unsigned COND_W        = 18;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] COND_RST      = 32'h0000_0000;

   // modem and channel-change conditions, bit 0 is qos_rsv
   typedef struct packed {
      logic micro_refl;  // new upstream error rate above 1 %
      logic ratio_n_chg;
      logic ratio_m_chg;
      logic mod_rate_chg;
      logic cdma_mode;
      logic atten_excess;
      logic delay_excess;
      logic access_switch;
      logic ucd_subst;
      logic sync_subst;
      logic ts_synced;
      logic us_change;
      logic ds_change;
      logic tcc_assigned;
      logic multi_rx;
      logic multi_tx;
      logic latest_gen;
      logic qos_rsv;
   } dcp_cond_t;

endpackage : dcp_pkg

// *** core/dcp_policy.sv ***
/*
 * dcp_policy: head-end channel-change policy with AHB-Lite registers.
 * computes the new-channel reservation timeout, checks the requested
 * technique and times the reservation. assumes ref_clk at 50 MHz and
 * a modem_detected level from another domain.
 */
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module dcp_policy #(
   parameter int unsigned MS_CYCLES = dcp_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // modem arrival, asynchronous level
   input  wire logic        modem_detected,
   // request issue side
   output logic             dcc_issue,
   output logic [2:0]       issue_tech,
   output logic             violation,
   output logic             reserve_hold,
   output logic             t15_valid
);

   // ==========================================================
   // bus slave
   logic        wr_pend_r;
   logic [7:0]  wr_addr_r;
   logic [31:0] ctrl_r;
   logic [15:0] jump_r;
   logic [15:0] sm_iv_r;
   logic [15:0] rng_iv_r;
   logic [dcp_pkg::COND_W-1:0] cond_r;
   logic [31:0] rd_nxt;
   logic        acc;
   logic        wr_ctrl;
   logic        wr_cfg;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign acc       = hsel & hready & htrans[1];
   assign wr_ctrl   = wr_pend_r & (wr_addr_r == dcp_pkg::OFS_CTRL);
   assign wr_cfg    = wr_pend_r & (wr_addr_r <= dcp_pkg::OFS_COND);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata    <= 32'h0000_0000;
      end else begin
         wr_pend_r <= acc & hwrite;
         wr_addr_r <= {haddr[7:2], 2'b00};
         if (acc && !hwrite) begin
            hrdata <= rd_nxt;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r   <= dcp_pkg::CTRL_RST;
         jump_r   <= 16'h0000;
         sm_iv_r  <= 16'h0000;
         rng_iv_r <= 16'h0000;
         cond_r   <= dcp_pkg::COND_RST[dcp_pkg::COND_W-1:0];
      end else if (wr_pend_r) begin
         unique case (wr_addr_r)
            dcp_pkg::OFS_CTRL:   ctrl_r   <= {23'h0, 1'b0, 4'h0,
                                              hwdata[3:0]};
            dcp_pkg::OFS_JUMP:   jump_r   <= hwdata[15:0];
            dcp_pkg::OFS_SM_IV:  sm_iv_r  <= hwdata[15:0];
            dcp_pkg::OFS_RNG_IV: rng_iv_r <= hwdata[15:0];
            dcp_pkg::OFS_COND:   cond_r   <= hwdata[dcp_pkg::COND_W-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // timeout computation, two register stages
   dcp_pkg::dcp_cond_t c;
   logic [2:0]  tech;
   logic        jv;
   logic [17:0] jump_term;
   logic [17:0] rng_term;
   logic [17:0] sum_r;
   logic [17:0] clamped;
   logic [15:0] t15_r;
   logic [1:0]  pipe_r;

   assign c    = cond_r;
   assign tech = ctrl_r[dcp_pkg::CTRL_TECH_LSB +: 3];
   assign jv   = ctrl_r[dcp_pkg::CTRL_JV_BIT];
   assign jump_term = jv ? {2'b00, jump_r}
                         : {2'b00, dcp_pkg::JUMP_DEF_MS};
   // technique 3 may fall back to initial ranging, so it gets the
   // broadcast allowance; technique 0 reserves nothing
   assign rng_term =
      (tech == dcp_pkg::TECH_DIRECT)  ? {1'b0, sm_iv_r, 1'b0}
                  + {2'b00, dcp_pkg::RNG_MARGIN_MS} :
      (tech == dcp_pkg::TECH_UNICAST) ? {1'b0, rng_iv_r, 1'b0}
                  + {2'b00, dcp_pkg::RNG_MARGIN_MS} :
      (tech == dcp_pkg::TECH_BCAST || tech == dcp_pkg::TECH_EITHER)
                  ? {2'b00, dcp_pkg::TECH1_RNG_MS} : 18'd0;
   assign clamped =
      (sum_r < dcp_pkg::T15_MIN_MS) ? dcp_pkg::T15_MIN_MS :
      (sum_r > dcp_pkg::T15_MAX_MS) ? dcp_pkg::T15_MAX_MS : sum_r;
   assign t15_valid = ~|pipe_r & ~wr_cfg;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sum_r  <= 18'd0;
         t15_r  <= 16'h0000;
         pipe_r <= 2'b11;
      end else begin
         sum_r  <= jump_term + rng_term;
         t15_r  <= clamped[15:0];
         pipe_r <= {pipe_r[0], wr_cfg};
      end
   end

   // ==========================================================
   // technique checks
   logic force0;
   logic subst_ok;
   logic ok1;
   logic ok2;
   logic ok4;
   logic viol;

   // newest modems, modems with both multi_rx and multi_tx, and multi_rx modems changing downstream only reinitialize
   assign force0 = ~c.qos_rsv
                 | (c.multi_rx & c.ds_change)
                 | (c.tcc_assigned & c.us_change)
                 | c.latest_gen
                 | (c.multi_tx & c.multi_rx);
   assign subst_ok = (~c.ds_change | (c.ts_synced & c.sync_subst))
                   & (~c.us_change | c.ucd_subst);
   // substitution data is optional for technique 1
   assign ok1  = c.qos_rsv;
   assign ok2  = subst_ok
               & ~c.access_switch & ~c.delay_excess
               & ~c.atten_excess;
   assign ok4  = ok2
               & ~(c.cdma_mode & (c.mod_rate_chg | c.ratio_m_chg
                  | c.ratio_n_chg | c.ds_change))
               & ~c.micro_refl;
   always_comb begin
      unique case (tech)
         dcp_pkg::TECH_REINIT:  viol = 1'b0;
         dcp_pkg::TECH_BCAST:   viol = force0 | ~ok1;
         dcp_pkg::TECH_UNICAST: viol = force0 | ~ok2;
         dcp_pkg::TECH_EITHER:  viol = force0 | ~(ok1 & ok2);
         dcp_pkg::TECH_DIRECT:  viol = force0 | ~ok4;
         default:               viol = 1'b1;
      endcase
   end

   // ==========================================================
   // issue and reservation timing
   logic        iss_pend_r;
   logic        refused_r;
   logic        fire;
   logic [15:0] res_ms_r;
   logic [31:0] pre_r;
   logic        tick;
   logic [1:0]  det_r;
   logic        det;

   assign fire = iss_pend_r & t15_valid;
   assign tick = (pre_r == MS_CYCLES - 1);
   assign det  = det_r[1];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         det_r <= 2'b00;
      end else begin
         det_r <= {det_r[0], modem_detected};
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         iss_pend_r <= 1'b0;
         refused_r  <= 1'b0;
         dcc_issue  <= 1'b0;
         issue_tech <= 3'h0;
         violation  <= 1'b0;
      end else begin
         violation  <= viol;
         dcc_issue  <= fire & ~viol;
         if (wr_ctrl && hwdata[dcp_pkg::CTRL_ISS_BIT]) begin
            iss_pend_r <= 1'b1;
         end else if (fire) begin
            iss_pend_r <= 1'b0;
         end
         if (fire) begin
            refused_r  <= viol;
            issue_tech <= tech;
         end
      end
   end

   // timer never exceeds t15, so nothing is held past it
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reserve_hold <= 1'b0;
         res_ms_r     <= 16'h0000;
         pre_r        <= 32'h0;
      end else if (fire && !viol && tech != dcp_pkg::TECH_REINIT) begin
         reserve_hold <= 1'b1;
         res_ms_r     <= t15_r;
         pre_r        <= 32'h0;
      end else if (reserve_hold) begin
         pre_r <= tick ? 32'h0 : pre_r + 32'h1;
         if (tick) begin
            res_ms_r <= res_ms_r - 16'h1;
         end
         if (det || (tick && res_ms_r <= 16'h1)) begin
            reserve_hold <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read mux
   always_comb begin
      unique case ({haddr[7:2], 2'b00})
         dcp_pkg::OFS_CTRL:   rd_nxt = {28'h0, ctrl_r[3:0]};
         dcp_pkg::OFS_JUMP:   rd_nxt = {16'h0, jump_r};
         dcp_pkg::OFS_SM_IV:  rd_nxt = {16'h0, sm_iv_r};
         dcp_pkg::OFS_RNG_IV: rd_nxt = {16'h0, rng_iv_r};
         dcp_pkg::OFS_COND:   rd_nxt = {14'h0, cond_r};
         dcp_pkg::OFS_STAT:   rd_nxt = {26'h0, det, iss_pend_r,
                                refused_r, reserve_hold, t15_valid,
                                violation};
         dcp_pkg::OFS_T15:    rd_nxt = {16'h0, t15_r};
         dcp_pkg::OFS_REMAIN: rd_nxt = {16'h0, res_ms_r};
         default:             rd_nxt = 32'h0;
      endcase
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   logic [17:0] e_sum;
   logic [15:0] t15_at_iss;
   assign e_sum = jump_term + rng_term;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         t15_at_iss <= 16'h0;
      end else if (fire) begin
         t15_at_iss <= t15_r;
      end
   end

   property p_sum;
      t15_valid && e_sum >= dcp_pkg::T15_MIN_MS
         && e_sum <= dcp_pkg::T15_MAX_MS |-> t15_r == e_sum[15:0];
   endproperty
   a_sum: assert property (p_sum)
      else $error("timeout not the sum of its terms");

   property p_def_jump;
      t15_valid && !jv && tech == dcp_pkg::TECH_BCAST |->
         t15_r == 16'd31300;
   endproperty
   a_def_jump: assert property (p_def_jump)
      else $error("default jump time not applied");

   property p_clamp;
      t15_valid |-> t15_r >= 16'd4000 && t15_r <= 16'd35000;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("timeout outside 4 s to 35 s");

   property p_direct;
      t15_valid && jv && tech == dcp_pkg::TECH_DIRECT && jump_r == 16'd4000
         && sm_iv_r < 16'd100 |-> t15_r == 16'd4030 + {sm_iv_r, 1'b0};
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct technique allowance wrong");

   property p_no_viol_issue;
      dcc_issue |-> !$past(viol);
   endproperty
   a_no_viol_issue: assert property (p_no_viol_issue)
      else $error("request issued despite violation");

   property p_force0;
      dcc_issue |-> issue_tech == dcp_pkg::TECH_REINIT || !$past(force0);
   endproperty
   a_force0: assert property (p_force0)
      else $error("non-zero technique where zero is required");

   property p_tech4;
      dcc_issue && issue_tech == dcp_pkg::TECH_DIRECT |->
         !$past(c.micro_refl) && !$past(c.access_switch);
   endproperty
   a_tech4: assert property (p_tech4)
      else $error("direct technique under a barred condition");

   property p_hold_start;
      dcc_issue && issue_tech != dcp_pkg::TECH_REINIT |-> reserve_hold
         && res_ms_r == t15_at_iss;
   endproperty
   a_hold_start: assert property (p_hold_start)
      else $error("reservation not started on issue");

   property p_hold_bound;
      reserve_hold |-> res_ms_r <= t15_at_iss;
   endproperty
   a_hold_bound: assert property (p_hold_bound)
      else $error("reservation longer than timeout");

   property p_ready;
      wr_cfg ##1 !wr_cfg [*3] |-> t15_valid;
   endproperty
   a_ready: assert property (p_ready)
      else $error("timeout not ready two cycles after input");

endmodule : dcp_policy

`default_nettype wire

// *** tb/dcp_modem_model.sv ***
/*
 * dcp_modem_model: far-side modem stand-in for the policy bench.
 * assumes the bench raises arrive when the modem should move; the
 * arrival level then rises delay_cyc + 1 cycles later, and drops with it.
 */
`timescale 1ns/1ns
`default_nettype none
module dcp_modem_model #(
   parameter int unsigned RESYNC_MS  = 200,
   parameter int unsigned CLEANUP_MS = 50,
   parameter int unsigned T11_MS     = 3000
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // bench control
   input  wire logic        arrive,
   input  wire logic [7:0]  delay_cyc,
   // modem side
   output logic [15:0]      jump_report_ms,
   output logic             modem_detected
);
   logic [7:0] wait_r;

   // ==========================================================
   // depart report: resync, old-channel cleanup and one t11
   assign jump_report_ms = 16'(RESYNC_MS + CLEANUP_MS + T11_MS);

   // ==========================================================
   // arrival, prompt or slow as the bench asks
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wait_r         <= 8'h00;
         modem_detected <= 1'b0;
      end else if (!arrive) begin
         wait_r         <= 8'h00;
         modem_detected <= 1'b0;
      end else if (wait_r == delay_cyc) begin
         modem_detected <= 1'b1;
      end else begin
         wait_r <= wait_r + 8'h01;
      end
   end
endmodule : dcp_modem_model
`default_nettype wire

// *** tb/testbench.sv ***
/*
 * testbench: self-checking bench for dcp_policy over ahb-lite.
 * assumes one slave on the bus and the modem stand-in on the far side.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int unsigned MSC = 4;
   logic        ref_clk, nrst, hsel, hwrite, hreadyout, hresp, arrive;
   logic        modem_detected, dcc_issue, violation, reserve_hold;
   logic        t15_valid;
   logic [1:0]  htrans;
   logic [2:0]  hsize, issue_tech;
   logic [7:0]  delay_cyc;
   logic [15:0] jump_ms;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          n_mismatch, tests_run, n;

   dcp_policy #(.MS_CYCLES(MSC)) u_dut (
      .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .modem_detected(modem_detected),
      .dcc_issue(dcc_issue), .issue_tech(issue_tech),
      .violation(violation), .reserve_hold(reserve_hold),
      .t15_valid(t15_valid));
   dcp_modem_model u_modem (
      .ref_clk(ref_clk), .nrst(nrst), .arrive(arrive),
      .delay_cyc(delay_cyc), .jump_report_ms(jump_ms),
      .modem_detected(modem_detected));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // compare and finish
   task automatic check(input string what, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task automatic conclude();
      if (n_mismatch == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   // ==========================================================
   // bounded waits; these end on a falling edge
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = t15_valid;
         1: pick = dcc_issue;
         default: pick = reserve_hold;
      endcase
   endfunction : pick

   task automatic wait_sig(input int sel, input logic lvl, input int lim);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
         if (n > lim) begin
            check("wait limit", 32'h1, 32'h0);
            conclude();
         end
      end while (pick(sel) !== lvl);
   endtask : wait_sig

   // ==========================================================
   // ahb-lite master; entered and left just after a rising edge
   task automatic ahb_ready();
      int k;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
         if (k > 50) begin
            check("hready wait", 32'h1, 32'h0);
            conclude();
         end
      end while (hreadyout !== 1'b1);
      check("hresp", 32'h0, {31'h0, hresp});
   endtask : ahb_ready

   task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                           input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      ahb_ready();
      htrans <= 2'b00;
      hwdata <= d;
      ahb_ready();
      rd = hrdata;
   endtask : ahb_xfer

   // ==========================================================
   // scenario helpers
   task automatic t15_case(input logic [2:0] tech, input logic jv,
                           input logic [15:0] jump, sm, rg);
      logic [31:0] e;
      e = jv ? 32'(jump) : 32'(dcp_pkg::JUMP_DEF_MS);
      case (tech)
         3'h4: e = e + 2 * 32'(sm) + 32'(dcp_pkg::RNG_MARGIN_MS);
         3'h2: e = e + 2 * 32'(rg) + 32'(dcp_pkg::RNG_MARGIN_MS);
         3'h1, 3'h3: e = e + 32'(dcp_pkg::TECH1_RNG_MS);
         default: e = e;
      endcase
      if (e < 32'(dcp_pkg::T15_MIN_MS)) e = 32'(dcp_pkg::T15_MIN_MS);
      if (e > 32'(dcp_pkg::T15_MAX_MS)) e = 32'(dcp_pkg::T15_MAX_MS);
      ahb_xfer(1'b1, dcp_pkg::OFS_JUMP, 32'(jump));
      ahb_xfer(1'b1, dcp_pkg::OFS_SM_IV, 32'(sm));
      ahb_xfer(1'b1, dcp_pkg::OFS_RNG_IV, 32'(rg));
      ahb_xfer(1'b1, dcp_pkg::OFS_CTRL, 32'(tech) | (32'(jv) << 3));
      wait_sig(0, 1'b1, 10);
      check("t15 latency", 32'd3, 32'(n));
      @(posedge ref_clk);
      ahb_xfer(1'b0, dcp_pkg::OFS_T15, 32'h0);
      check("t15 ms", e, rd);
   endtask : t15_case

   task automatic viol(input logic [2:0] tech, input logic [17:0] c,
                       input logic e);
      ahb_xfer(1'b1, dcp_pkg::OFS_COND, 32'(c));
      ahb_xfer(1'b1, dcp_pkg::OFS_CTRL, 32'(tech));
      wait_sig(0, 1'b1, 10);
      @(negedge ref_clk);
      check("violation", 32'(e), 32'(violation));
      @(posedge ref_clk);
   endtask : viol

   task automatic issue(input logic [31:0] ctrl);
      ahb_xfer(1'b1, dcp_pkg::OFS_CTRL, ctrl);
      wait_sig(1, 1'b1, 20);
      check("issue tech", ctrl & 32'h7, 32'(issue_tech));
   endtask : issue

   // ==========================================================
   // main sequence
   initial begin
      n_mismatch = 0;
      tests_run  = 0;
      nrst       = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0;
      htrans     = 2'b00;
      hwrite     = 1'b0;
      hsize      = 3'h2;
      hwdata     = 32'h0;
      arrive     = 1'b0;
      delay_cyc  = 8'h05;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      ahb_xfer(1'b0, dcp_pkg::OFS_CTRL, 32'h0);
      check("ctrl reset", dcp_pkg::CTRL_RST, rd);
      ahb_xfer(1'b0, dcp_pkg::OFS_COND, 32'h0);
      check("cond reset", dcp_pkg::COND_RST, rd);
      ahb_xfer(1'b1, 8'h20, 32'hffff_ffff);
      ahb_xfer(1'b0, 8'h20, 32'h0);
      check("unmapped read", 32'h0, rd);
      t15_case(3'h1, 1'b0, 16'd9000, 16'd0, 16'd0);
      t15_case(3'h1, 1'b1, 16'd6000, 16'd0, 16'd0);
      t15_case(3'h2, 1'b1, jump_ms, 16'd0, 16'd1000);
      t15_case(3'h4, 1'b1, 16'd3000, 16'd800, 16'd0);
      t15_case(3'h4, 1'b1, 16'd100, 16'd50, 16'd0);
      t15_case(3'h4, 1'b1, 16'd4000, 16'd50, 16'd0);
      t15_case(3'h3, 1'b0, 16'd0, 16'd0, 16'd0);
      viol(3'h0, 18'h00000, 1'b0);
      viol(3'h1, 18'h00000, 1'b1);
      viol(3'h1, 18'h00001, 1'b0);
      viol(3'h1, 18'h00003, 1'b1);
      viol(3'h1, 18'h0000d, 1'b1);
      viol(3'h1, 18'h00029, 1'b1);
      viol(3'h1, 18'h00051, 1'b1);
      viol(3'h2, 18'h00021, 1'b1);
      viol(3'h2, 18'h001a1, 1'b0);
      viol(3'h2, 18'h00041, 1'b1);
      viol(3'h2, 18'h00241, 1'b0);
      viol(3'h2, 18'h00401, 1'b1);
      viol(3'h2, 18'h00801, 1'b1);
      viol(3'h2, 18'h01001, 1'b1);
      viol(3'h3, 18'h00001, 1'b0);
      viol(3'h3, 18'h00801, 1'b1);
      viol(3'h4, 18'h00021, 1'b1);
      viol(3'h4, 18'h00241, 1'b0);
      viol(3'h4, 18'h02001, 1'b0);
      viol(3'h4, 18'h06001, 1'b1);
      viol(3'h4, 18'h0a001, 1'b1);
      viol(3'h4, 18'h12001, 1'b1);
      viol(3'h4, 18'h021a1, 1'b1);
      viol(3'h4, 18'h00401, 1'b1);
      viol(3'h4, 18'h01001, 1'b1);
      viol(3'h4, 18'h20001, 1'b1);
      viol(3'h5, 18'h00001, 1'b1);
      // refused request: no pulse, flag up, technique still shown
      ahb_xfer(1'b1, dcp_pkg::OFS_CTRL, 32'h0000_0105);
      n = 0;
      repeat (10) begin
         @(negedge ref_clk);
         if (dcc_issue !== 1'b0) n++;
      end
      check("refused pulse", 32'h0, 32'(n));
      check("refused tech", 32'h5, 32'(issue_tech));
      @(posedge ref_clk);
      ahb_xfer(1'b0, dcp_pkg::OFS_STAT, 32'h0);
      check("refused flag", 32'h1, {31'h0, rd[3]});
      issue(32'h0000_0100);
      check("reinit hold", 32'h0, {31'h0, reserve_hold});
      @(posedge ref_clk);
      // t15 here clamps to the minimum; hold runs that many ms
      issue(32'h0000_010c);
      check("hold set", 32'h1, {31'h0, reserve_hold});
      @(posedge ref_clk);
      ahb_xfer(1'b0, dcp_pkg::OFS_REMAIN, 32'h0);
      check("remain start", 32'(dcp_pkg::T15_MIN_MS), rd);
      wait_sig(2, 1'b0, 20000);
      check("hold span", 32'h1, {31'h0, n > 15984 && n < 16016});
      @(posedge ref_clk);
      issue(32'h0000_010c);
      @(posedge ref_clk);
      arrive <= 1'b1;
      wait_sig(2, 1'b0, 40);
      check("arrival drop", 32'h1, {31'h0, n <= 16});
      @(posedge ref_clk);
      arrive <= 1'b0;
      conclude();
   end
endmodule : testbench
`default_nettype wire
